// [design/touch_sense_map.svh]
// Register indices, field positions, reset values, the maximum scale and the sequence seeds of the touch-sense block
`ifndef TOUCH_SENSE_MAP_SVH
`define TOUCH_SENSE_MAP_SVH

// Register indices; the AHB byte address is four times the index
`define EVENT_STATUS_MASK_IDX 8'hA6
`define TIMER_COUNT_IDX       8'hA7
`define SLEW_BOOST_IDX        8'hA8
`define PRESCALER_SEQ_IDX     8'hA9

`define EVENT_STATUS_MASK_RST 8'h00
`define TIMER_COUNT_RST       7'h00
`define SLEW_BOOST_RST        8'h00
`define PRESCALER_SEQ_RST     8'h00

// Status flags 7:4 pair with masks 3:0 in the same order
`define FLAG_MSB 7
`define FLAG_LSB 4
`define MASK_MSB 3
`define MASK_LSB 0
`define TIMER_MSB 6

`define SLEW_LEN_MSB 7
`define SLEW_LEN_LSB 1
`define SLEW_EN_BIT  0

`define ROUTE_BIT    7
`define INVERT_BIT   6
`define LONG_BIT     5
`define SEQ_EN_BIT   4
`define BYPASS_BIT   3
`define RATIO_MSB    2
`define RATIO_LSB    0

`define SCALE_MAX    2'h3
`define SEQ8_SEED    8'h01
`define SEQ12_SEED   12'h001

`endif

// [design/touch_sense_pkg.sv]
// Types shared by the touch-sense block
package touch_sense_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] scale_t;
  typedef logic [3:0] event_t;
endpackage : touch_sense_pkg

// [design/prescaler_seq_if.sv]
// Control and outputs between the register logic and the prescaler/sequence generator
`timescale 1ns/100ps
`default_nettype none
interface prescaler_seq_if;
  logic       divider_bypass;
  logic [2:0] divider_ratio;
  logic       random_seq_enable;
  logic       random_seq_long_select;
  logic       divided_clock;
  logic       random_out;
  modport ctrl (output divider_bypass, divider_ratio, random_seq_enable,
                random_seq_long_select, input divided_clock, random_out);
  modport gen  (input divider_bypass, divider_ratio, random_seq_enable,
                random_seq_long_select, output divided_clock, random_out);
endinterface : prescaler_seq_if
`default_nettype wire

// [design/prescaler_seq.sv]
// Oscillator prescaler and pseudo-random sequence generator
`timescale 1ns/100ps
`default_nettype none
`include "touch_sense_map.svh"
module prescaler_seq
  import touch_sense_pkg::*;
#(
  parameter int LONG_WIDTH = 12
)(
  input  wire logic      clk,
  input  wire logic      rst_n,
  prescaler_seq_if.gen   seq
);
  // The feedback taps are fixed for the 12-bit polynomial
  if (LONG_WIDTH != 12)
  begin : g_width_check
    $error("prescaler_seq supports only a 12-bit long sequence");
  end

  logic [6:0]            half_cnt_reg;
  logic [6:0]            half_last;
  logic                  divided_reg;
  logic                  tick;
  logic [7:0]            seq8_reg;
  logic [LONG_WIDTH-1:0] seq12_reg;
  logic                  random_reg;

  // Half period is 2^n cycles, so the full period is 2^(n+1)
  assign half_last = 7'((8'h01 << seq.divider_ratio) - 8'h01);
  // Bypass advances the sequence every cycle; the pin copy is then a half-rate toggle
  assign tick = seq.divider_bypass || (half_cnt_reg == half_last && !divided_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt_reg <= 7'h00;
      divided_reg  <= 1'b0;
    end
    else if (seq.divider_bypass || half_cnt_reg >= half_last)
    begin
      half_cnt_reg <= 7'h00;
      divided_reg  <= ~divided_reg;
    end
    else
      half_cnt_reg <= half_cnt_reg + 7'h01;
  end

  // Maximal-length taps: x^8+x^6+x^5+x^4+1 and x^12+x^6+x^4+x+1
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq8_reg  <= `SEQ8_SEED;
      seq12_reg <= `SEQ12_SEED;
    end
    else if (tick && seq.random_seq_enable)
    begin
      seq8_reg  <= {seq8_reg[6:0], seq8_reg[7] ^ seq8_reg[5] ^ seq8_reg[4] ^ seq8_reg[3]};
      seq12_reg <= {seq12_reg[10:0],
                    seq12_reg[11] ^ seq12_reg[5] ^ seq12_reg[3] ^ seq12_reg[0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      random_reg <= 1'b0;
    else if (!seq.random_seq_enable)
      random_reg <= 1'b0;
    else
      random_reg <= seq.random_seq_long_select ? seq12_reg[11] : seq8_reg[7];
  end

  assign seq.divided_clock = divided_reg;
  assign seq.random_out    = random_reg;

  a_seq_off_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !seq.random_seq_enable |=> !seq.random_out)
    else $error("sequence output not zero while disabled");
  // Sampled reset in the window keeps the edge that leaves reset out of it
  a_div_two_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && seq.divider_ratio == 3'h0 && !seq.divider_bypass)[*2] |->
    divided_reg != $past(divided_reg))
    else $error("divide by two does not toggle each cycle");
  a_seq_nonzero: assert property (@(posedge clk) disable iff (!rst_n)
    seq8_reg != 8'h00 && seq12_reg != 12'h000)
    else $error("sequence register reached zero");

endmodule : prescaler_seq
`default_nettype wire

// [design/touch_sense_status_slew.sv]
// Status/mask, sense timer, fast-slew boost and pin routing with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "touch_sense_map.svh"
module touch_sense_status_slew
  import touch_sense_pkg::*;
#(
  parameter int DATA_WIDTH = 32
)(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        SENSE_INPUT,
  input  wire logic        LOW_CARRY,
  input  wire logic        HIGH_CARRY,
  input  wire logic        MEASURE_DONE,
  input  wire logic        RELAX_OSC,
  input  wire logic [1:0]  CURRENT_SCALE,
  input  wire logic        SIGMA_DELTA_SENSE_MODE,
  input  wire logic        SWITCH_CLOCK_SOURCE_SELECT,
  input  wire logic [1:0]  SENSE_CLOCK_DIVIDER_SELECT,
  input  wire logic [1:0]  SENSE_SIGNAL_PIN_SELECT,
  output logic [1:0]       EFFECTIVE_CURRENT_SCALE,
  output logic             SWITCH_CLOCK,
  output logic             SENSE_PIN_OUT,
  output logic [6:0]       TIMER_COUNT,
  output logic             SENSE_IRQ
);
  // Read data and lane decoding are built for one 32-bit word
  if (DATA_WIDTH != 32)
  begin : g_width_check
    $error("touch_sense_status_slew needs 32-bit AHB data");
  end

  logic [1:0]  rst_sync_reg;
  logic        rst_n_int;
  logic [2:0]  in_sync_reg;
  logic        in_level_reg;
  logic [2:0]  osc_sync_reg;
  logic        osc_level_reg;
  logic        input_rise;
  logic        osc_edge;
  event_t      flag_reg;
  event_t      flag_next;
  event_t      mask_reg;
  event_t      events;
  logic [6:0]  timer_reg;
  byte_t       slew_reg;
  byte_t       seq_ctrl_reg;
  logic [6:0]  boost_cnt_reg;
  logic        boost_active;
  logic        irq_reg;
  scale_t      scale_reg;
  logic [2:0]  sense_div_reg;
  logic        sense_clock;
  logic        pin_reg;
  logic        switch_reg;
  logic        wr_pending_reg;
  logic        rd_wait_reg;
  logic        mapped_reg;
  byte_t       idx_reg;
  logic [31:0] rdata_reg;
  logic        addr_phase;
  logic        wr_now;
  logic        status_wr;

  prescaler_seq_if seq ();

  prescaler_seq #(
    .LONG_WIDTH (12)
  ) u_prescaler_seq (
    .clk   (CLOCK),
    .rst_n (rst_n_int),
    .seq   (seq)
  );

  // Release is synchronised so no flop leaves reset on a different edge
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n_int = rst_sync_reg[1];

  // Pin inputs: three flops, a change counts once the last two agree
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      in_sync_reg   <= 3'b000;
      in_level_reg  <= 1'b0;
      osc_sync_reg  <= 3'b000;
      osc_level_reg <= 1'b0;
    end
    else
    begin
      in_sync_reg  <= {in_sync_reg[1:0], SENSE_INPUT};
      osc_sync_reg <= {osc_sync_reg[1:0], RELAX_OSC};
      if (in_sync_reg[2] == in_sync_reg[1])
        in_level_reg <= in_sync_reg[2];
      if (osc_sync_reg[2] == osc_sync_reg[1])
        osc_level_reg <= osc_sync_reg[2];
    end
  end

  assign input_rise = !in_level_reg && in_sync_reg[2] && in_sync_reg[1];
  // Either direction of the oscillator counts, once the filter agrees
  assign osc_edge   = osc_level_reg != osc_sync_reg[2] && osc_sync_reg[2] == osc_sync_reg[1];
  assign events     = {input_rise, LOW_CARRY, HIGH_CARRY, MEASURE_DONE};

  // AHB-Lite slave: writes take no wait, reads take one wait state
  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign wr_now     = wr_pending_reg && mapped_reg;
  assign status_wr  = wr_now && idx_reg == `EVENT_STATUS_MASK_IDX;

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      wr_pending_reg <= 1'b0;
      rd_wait_reg    <= 1'b0;
      mapped_reg     <= 1'b0;
      idx_reg        <= 8'h00;
    end
    else
    begin
      wr_pending_reg <= addr_phase && HWRITE;
      rd_wait_reg    <= addr_phase && !HWRITE;
      if (addr_phase)
      begin
        idx_reg    <= HADDR[9:2];
        mapped_reg <= HADDR[31:10] == 22'h000000 && HADDR[1:0] == 2'b00;
      end
    end
  end

  function automatic byte_t read_mux(input byte_t idx, input logic mapped,
                                     input byte_t stat, input logic [6:0] tmr,
                                     input byte_t slew, input byte_t ctl);
    byte_t v;
    v = 8'h00;
    if (mapped)
    begin
      case (idx)
        `EVENT_STATUS_MASK_IDX: v = stat;
        `TIMER_COUNT_IDX:       v = {1'b0, tmr};
        `SLEW_BOOST_IDX:        v = slew;
        `PRESCALER_SEQ_IDX:     v = ctl;
        default:                v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_mux

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      rdata_reg <= 32'h00000000;
    else if (rd_wait_reg)
      rdata_reg <= {24'h000000, read_mux(idx_reg, mapped_reg, {flag_reg, mask_reg},
                                         timer_reg, slew_reg, seq_ctrl_reg)};
  end

  assign HREADYOUT = !rd_wait_reg;
  assign HRDATA    = rdata_reg;
  assign HRESP     = 1'b0;

  // An event in the clearing write's cycle still sets its flag
  always_comb
  begin
    flag_next = flag_reg;
    if (status_wr)
      flag_next = flag_reg & HWDATA[`FLAG_MSB:`FLAG_LSB];
    flag_next = flag_next | events;
  end

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      flag_reg <= 4'(`EVENT_STATUS_MASK_RST >> `FLAG_LSB);
      mask_reg <= 4'(`EVENT_STATUS_MASK_RST);
    end
    else
    begin
      flag_reg <= flag_next;
      if (status_wr)
        mask_reg <= HWDATA[`MASK_MSB:`MASK_LSB];
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flag_reg & mask_reg);
  end
  assign SENSE_IRQ = irq_reg;

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      timer_reg    <= `TIMER_COUNT_RST;
      slew_reg     <= `SLEW_BOOST_RST;
      seq_ctrl_reg <= `PRESCALER_SEQ_RST;
    end
    else if (wr_now)
    begin
      if (idx_reg == `TIMER_COUNT_IDX)
        timer_reg <= HWDATA[`TIMER_MSB:0];
      if (idx_reg == `SLEW_BOOST_IDX)
        slew_reg <= HWDATA[7:0];
      if (idx_reg == `PRESCALER_SEQ_IDX)
        seq_ctrl_reg <= HWDATA[7:0];
    end
  end
  assign TIMER_COUNT = timer_reg;

  // Fast slew: each oscillator edge reloads; zero length gives no boost
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      boost_cnt_reg <= 7'h00;
    else if (!slew_reg[`SLEW_EN_BIT])
      boost_cnt_reg <= 7'h00;
    else if (osc_edge)
      boost_cnt_reg <= slew_reg[`SLEW_LEN_MSB:`SLEW_LEN_LSB];
    else if (boost_cnt_reg != 7'h00)
      boost_cnt_reg <= boost_cnt_reg - 7'h01;
  end
  assign boost_active = boost_cnt_reg != 7'h00;

  // Only the effective copy is forced; the programmed scale stays readable
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      scale_reg <= 2'h0;
    else if (boost_active)
      scale_reg <= `SCALE_MAX;
    else
      scale_reg <= CURRENT_SCALE;
  end
  assign EFFECTIVE_CURRENT_SCALE = scale_reg;

  assign seq.divider_bypass         = seq_ctrl_reg[`BYPASS_BIT];
  assign seq.divider_ratio          = seq_ctrl_reg[`RATIO_MSB:`RATIO_LSB];
  assign seq.random_seq_enable      = seq_ctrl_reg[`SEQ_EN_BIT];
  assign seq.random_seq_long_select = seq_ctrl_reg[`LONG_BIT];

  // Undivided oscillator cannot leave as data, so select 00 and 01 both give half rate
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      sense_div_reg <= 3'h0;
    else
      sense_div_reg <= sense_div_reg + 3'h1;
  end

  always_comb
  begin
    sense_clock = sense_div_reg[0];
    if (SIGMA_DELTA_SENSE_MODE)
      sense_clock = SWITCH_CLOCK_SOURCE_SELECT ? seq.random_out : seq.divided_clock;
    else if (SENSE_CLOCK_DIVIDER_SELECT == 2'h2)
      sense_clock = sense_div_reg[1];
    else if (SENSE_CLOCK_DIVIDER_SELECT == 2'h3)
      sense_clock = sense_div_reg[2];
  end

  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      pin_reg    <= 1'b0;
      switch_reg <= 1'b0;
    end
    else
    begin
      switch_reg <= SWITCH_CLOCK_SOURCE_SELECT ? seq.random_out : seq.divided_clock;
      if (seq_ctrl_reg[`ROUTE_BIT])
        pin_reg <= sense_clock ^ seq_ctrl_reg[`INVERT_BIT];
      else
      begin
        case (SENSE_SIGNAL_PIN_SELECT)
          2'h0:    pin_reg <= in_level_reg;
          2'h1:    pin_reg <= irq_reg;
          2'h2:    pin_reg <= LOW_CARRY;
          default: pin_reg <= HIGH_CARRY;
        endcase
      end
    end
  end
  assign SWITCH_CLOCK  = switch_reg;
  assign SENSE_PIN_OUT = pin_reg;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n_int);

  a_input_edge_set: assert property (input_rise |=> flag_reg[3])
    else $error("input edge did not set its flag");
  a_low_carry_set: assert property (LOW_CARRY |=> flag_reg[2])
    else $error("low carry did not set its flag");
  a_high_carry_set: assert property (HIGH_CARRY |=> flag_reg[1])
    else $error("high carry did not set its flag");
  a_done_flag_clear: assert property (
    status_wr && !HWDATA[4] && !MEASURE_DONE |=> !flag_reg[0])
    else $error("measurement flag not cleared by zero write");
  a_write_one_keeps: assert property (
    status_wr && &HWDATA[7:4] |=> flag_reg == ($past(flag_reg) | $past(events)))
    else $error("writing ones changed a flag");
  a_irq_follows_mask: assert property (
    ##1 SENSE_IRQ == $past(|(flag_reg & mask_reg)))
    else $error("interrupt does not follow flags and masks");
  a_boost_forces_max: assert property (
    boost_active |=> EFFECTIVE_CURRENT_SCALE == 2'h3)
    else $error("boost did not force maximum scale");
  a_boost_len_one: assert property (
    boost_cnt_reg == 7'h01 && slew_reg[`SLEW_EN_BIT] && !osc_edge |=> !boost_active)
    else $error("boost length one lasted too long");
  a_boost_disabled: assert property (!slew_reg[`SLEW_EN_BIT] |=> !boost_active)
    else $error("boost ran while disabled");
  a_timer_hold: assert property (!wr_now |=> TIMER_COUNT == $past(TIMER_COUNT))
    else $error("timer count changed without a write");

endmodule : touch_sense_status_slew
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the touch-sense status, slew and prescaler block
`timescale 1ns/100ps
`default_nettype none
`include "touch_sense_map.svh"
module tb;
  logic        CLOCK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, HREADY;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS, CURRENT_SCALE, EFFECTIVE_CURRENT_SCALE;
  logic [2:0]  HSIZE;
  logic        SENSE_INPUT, LOW_CARRY, HIGH_CARRY, MEASURE_DONE, RELAX_OSC;
  logic        SIGMA_DELTA_SENSE_MODE, SWITCH_CLOCK_SOURCE_SELECT, SWITCH_CLOCK;
  logic [1:0]  SENSE_CLOCK_DIVIDER_SELECT, SENSE_SIGNAL_PIN_SELECT;
  logic        SENSE_PIN_OUT, SENSE_IRQ;
  logic [6:0]  TIMER_COUNT;
  logic [7:0]  mdl [4];
  int          n_mismatch, n_compared, cyc, seed, p, c, i;
  int          ln [5];
  logic [1:0]  sc;
  logic [31:0] d, v;

  // Single slave: its ready is the bus ready
  assign HREADY = HREADYOUT;

  touch_sense_status_slew #(.DATA_WIDTH(32)) i_touch_sense_status_slew (
    .CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .SENSE_INPUT(SENSE_INPUT),
    .LOW_CARRY(LOW_CARRY), .HIGH_CARRY(HIGH_CARRY), .MEASURE_DONE(MEASURE_DONE),
    .RELAX_OSC(RELAX_OSC), .CURRENT_SCALE(CURRENT_SCALE),
    .SIGMA_DELTA_SENSE_MODE(SIGMA_DELTA_SENSE_MODE),
    .SWITCH_CLOCK_SOURCE_SELECT(SWITCH_CLOCK_SOURCE_SELECT),
    .SENSE_CLOCK_DIVIDER_SELECT(SENSE_CLOCK_DIVIDER_SELECT),
    .SENSE_SIGNAL_PIN_SELECT(SENSE_SIGNAL_PIN_SELECT),
    .EFFECTIVE_CURRENT_SCALE(EFFECTIVE_CURRENT_SCALE), .SWITCH_CLOCK(SWITCH_CLOCK),
    .SENSE_PIN_OUT(SENSE_PIN_OUT), .TIMER_COUNT(TIMER_COUNT), .SENSE_IRQ(SENSE_IRQ));

  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Ceiling well above the roughly 9000 cycles the sequence needs
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] ad(input int k);
    return {22'h0, 8'(`EVENT_STATUS_MASK_IDX + k), 2'h0};
  endfunction : ad

  // Ready is sampled before each rising edge, so the value seen is the settled one
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic rdy;
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= a;
    do
    begin
      @(negedge CLOCK);
      rdy = HREADYOUT;
      @(posedge CLOCK);
    end while (rdy !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do
    begin
      @(negedge CLOCK);
      rdy = HREADYOUT;
      rd  = HRDATA;
      @(posedge CLOCK);
    end while (rdy !== 1'b1);
    chk("response", 1'b0, HRESP);
  endtask : bus

  task automatic wr(input int k, input logic [7:0] x);
    logic [31:0] r;
    bus(1'b1, ad(k), {24'h0, x}, r);
    case (k)
      0: mdl[0] = {mdl[0][7:4] & x[7:4], x[3:0]};
      1: mdl[1] = {1'b0, x[6:0]};
      default: mdl[k] = x;
    endcase
  endtask : wr

  task automatic rmdl(input int k, input string nm);
    logic [31:0] r;
    bus(1'b0, ad(k), 32'h0, r);
    chk(nm, {24'h0, mdl[k]}, r);
  endtask : rmdl

  task automatic pulse(input int w);
    @(posedge CLOCK);
    case (w)
      0: SENSE_INPUT <= 1'b1;
      1: LOW_CARRY <= 1'b1;
      2: HIGH_CARRY <= 1'b1;
      default: MEASURE_DONE <= 1'b1;
    endcase
    // The pin input must outlast the synchroniser to count as an edge
    repeat ((w == 0) ? 3 : 1) @(posedge CLOCK);
    SENSE_INPUT  <= 1'b0;
    LOW_CARRY    <= 1'b0;
    HIGH_CARRY   <= 1'b0;
    MEASURE_DONE <= 1'b0;
    mdl[0][7-w] = 1'b1;
  endtask : pulse

  // Waits out the input synchroniser before judging interrupt and pin
  task automatic stchk();
    logic irq;
    repeat (8) @(negedge CLOCK);
    irq = |(mdl[0][7:4] & mdl[0][3:0]);
    chk("interrupt", irq, SENSE_IRQ);
    chk("pin shows irq", irq, SENSE_PIN_OUT);
    rmdl(0, "status");
  endtask : stchk

  // Period between the second and third rising edge, skipping any startup phase
  task automatic per(output int q);
    int   r;
    int   t0;
    logic pv;
    r  = 0;
    t0 = 0;
    q  = 0;
    pv = 1'b1;
    for (int k = 0; k < 1200 && r < 3; k++)
    begin
      @(negedge CLOCK);
      if (pv === 1'b0 && SENSE_PIN_OUT === 1'b1)
      begin
        r++;
        if (r == 3)
          q = k - t0;
        t0 = k;
      end
      pv = SENSE_PIN_OUT;
    end
  endtask : per

  task automatic tally(input int n, input logic eq, output int q);
    q = 0;
    repeat (n)
    begin
      @(negedge CLOCK);
      if (eq ? (SENSE_PIN_OUT === SWITCH_CLOCK) : (SWITCH_CLOCK === 1'b1))
        q++;
    end
  endtask : tally

  initial
  begin
    seed = 7335;
    RST_N = 1'b0;
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
    {SENSE_INPUT, LOW_CARRY, HIGH_CARRY, MEASURE_DONE, RELAX_OSC} = '0;
    CURRENT_SCALE = 2'h0;
    SIGMA_DELTA_SENSE_MODE = 1'b0;
    SWITCH_CLOCK_SOURCE_SELECT = 1'b0;
    SENSE_CLOCK_DIVIDER_SELECT = 2'h1;
    SENSE_SIGNAL_PIN_SELECT = 2'h1;
    for (i = 0; i < 4; i++)
      mdl[i] = 8'h00;
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    bus(1'b1, 32'h0000_0400, 32'hFF, d);
    bus(1'b0, 32'h0000_0400, 32'h0, d);
    chk("unmapped read", 32'h0, d);
    for (i = 0; i < 4; i++)
      rmdl(i, "reset value");
    v = $random(seed);
    wr(1, v[7:0]);
    rmdl(1, "timer");
    chk("timer port", mdl[1][6:0], TIMER_COUNT);
    wr(0, 8'h04);
    stchk();
    pulse(2);
    stchk();
    pulse(1);
    stchk();
    pulse(0);
    pulse(3);
    stchk();
    wr(0, 8'hFF);
    stchk();
    wr(0, 8'hBF);
    stchk();
    wr(0, 8'h70);
    stchk();
    wr(0, 8'h0F);
    stchk();
    ln = '{0, 1, 127, 0, 127};
    ln[3] = ($unsigned($random(seed)) % 126) + 1;
    for (i = 0; i < 5; i++)
    begin
      sc = 2'($unsigned($random(seed)) % 3);
      wr(2, {ln[i][6:0], i < 4});
      rmdl(2, "slew register");
      @(posedge CLOCK);
      RELAX_OSC <= ~RELAX_OSC;
      CURRENT_SCALE <= sc;
      c = 0;
      repeat (200)
      begin
        @(negedge CLOCK);
        if (EFFECTIVE_CURRENT_SCALE === 2'h3)
          c++;
      end
      chk("boost cycles", (i < 4) ? ln[i] : 0, c);
      chk("scale restored", sc, EFFECTIVE_CURRENT_SCALE);
    end
    @(posedge CLOCK);
    SIGMA_DELTA_SENSE_MODE <= 1'b1;
    for (i = 0; i < 9; i++)
    begin
      wr(3, (i < 8) ? (8'h80 | 8'(i)) : 8'h88);
      per(p);
      chk("divided period", (i < 8) ? (2 << i) : 2, p);
    end
    @(posedge CLOCK);
    SIGMA_DELTA_SENSE_MODE <= 1'b0;
    for (i = 1; i < 4; i++)
    begin
      @(posedge CLOCK);
      SENSE_CLOCK_DIVIDER_SELECT <= 2'(i);
      per(p);
      chk("sense clock period", 2 << (i - 1), p);
    end
    @(posedge CLOCK);
    SIGMA_DELTA_SENSE_MODE <= 1'b1;
    wr(3, 8'h87);
    tally(512, 1'b1, c);
    chk("pin follows clock", 1'b1, c >= 500);
    wr(3, 8'hC7);
    tally(512, 1'b1, c);
    chk("pin inverted", 1'b1, c <= 12);
    @(posedge CLOCK);
    SWITCH_CLOCK_SOURCE_SELECT <= 1'b1;
    wr(3, 8'h08);
    tally(300, 1'b0, c);
    chk("sequence off", 0, c);
    wr(3, 8'h18);
    repeat (10) @(negedge CLOCK);
    tally(1020, 1'b0, c);
    chk("short sequence ones", 512, c);
    wr(3, 8'h38);
    repeat (10) @(negedge CLOCK);
    tally(4095, 1'b0, c);
    chk("long sequence ones", 2048, c);
    summarize();
  end
endmodule : tb
`default_nettype wire
